// ===== rtl/i2c_block_regs.svh
/*
 * Register indices, field positions and reset values of the receive,
 * address and interrupt-control block.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef I2C_BLOCK_REGS_SVH
`define I2C_BLOCK_REGS_SVH

// ==========================================================
// Register indices on the 4-bit register address
`define RA_TXQ 4'h6
`define RA_RX 4'h7
`define RA_GC 4'h8
`define RA_ADDR 4'h9
`define RA_INTCR 4'ha
`define RA_INTSR 4'hb

// ==========================================================
// Field positions
`define ICR_REG_AUTOCLR 7
`define ICR_REG_FORCE 6
`define ICR_FIFO_AUTOCLR 9
`define ICR_FIFO_FORCE 8
`define ADDR_REG_LSB 2
`define RXQ_FIRST_BIT 8
`define FIFO_OVF_BIT 0

// ==========================================================
// Field masks and reset values
`define ICR_REG_MASK 8'hcf
`define ICR_FIFO_MASK 10'h37f
`define RST_ADDR 10'h000
`define RST_ICR_REG 8'h00
`define RST_ICR_FIFO 10'h000
`define RST_BYTE 8'h00
`define RST_WORD 10'h000

// ==========================================================
// Receive queue geometry
`define RXQ_DEPTH 32
`define RXQ_AW 5

`endif

// ===== rtl/i2c_rx_addr_irq_control.sv
/*
 * Receive path, general call byte, own address, interrupt control and
 * transmit-queue abort sequencing behind the 4-bit system bus.
 * Assumes the bit-level engine runs on sys_clk and hands over bytes,
 * events and busy levels as same-clock signals.
 */
//
// Overview of operation
// - Queue reset while transmitting finishes the current byte, then issues STOP.
// - Queue reset while receiving issues NACK then STOP to release the bus.
// - Receive location decodes its fields by the active mode.
// - Register mode holds the last received byte, bit 0 received last.
// - Queue entries carry the byte plus a first-after-START flag.
// - A write to the receive location in queue mode resets its pointers.
// - Second command byte of a general call is captured read-only.
// - Register mode address holds A9..A2, or A6..A2 for 7-bit; resets zero.
// - Queue mode address holds A9..A0, or A6..A0 for 7-bit; resets zero.
// - Register mode control: auto-clear, force and four interrupt enables, reset zero.
// - Queue mode control: auto-clear, force, reserved and seven enables, reset zero.
// - With auto-clear set, reading status clears all flags.
// - Force bit raises the request regardless of events.
// - Writing status clears each flag whose written bit is one.
// - Reading the transmit location in queue mode resets its pointers.
`timescale 1ns/1ps
`include "i2c_block_regs.svh"

module i2c_rx_addr_irq_control (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic fifo_mode,
    input wire logic fifo_rst,
    input wire logic bus_cs,
    input wire logic bus_stb,
    input wire logic bus_we,
    input wire logic [3:0] bus_addr,
    input wire logic [9:0] bus_wdata,
    output logic [9:0] bus_rdata,
    output logic bus_ack,
    input wire i2c_rx_pkg::rx_beat_t rx_beat,
    input wire logic gc_valid,
    input wire logic [7:0] gc_byte,
    input wire logic link_tx_busy,
    input wire logic link_rx_busy,
    input wire logic link_byte_done,
    input wire logic [3:0] reg_events,
    input wire logic [6:0] fifo_events,
    output logic [9:0] own_addr,
    output logic tx_queue_flush,
    output logic abort_stop,
    output logic abort_nack_stop,
    output logic rxq_empty,
    output logic irq
);

    // ======================================================
    // Reset release
    logic rst_meta_q;
    logic rst_sync_b;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_q <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_b <= rst_meta_q;
        end
    end

    // ======================================================
    // Bus decode
    i2c_rx_pkg::bus_req_t req;
    logic ack_q;
    logic [9:0] rdata_q;

    assign req = '{cs: bus_cs, stb: bus_stb, we: bus_we,
                   addr: bus_addr, wdata: bus_wdata};

    // One access per strobe: the ack cycle never retakes it
    wire taken = req.cs & req.stb & ~ack_q;
    wire wr = taken & req.we;
    wire rd = taken & ~req.we;
    wire hit_txq = req.addr == `RA_TXQ;
    wire hit_rx = req.addr == `RA_RX;
    wire hit_gc = req.addr == `RA_GC;
    wire hit_addr = req.addr == `RA_ADDR;
    wire hit_icr = req.addr == `RA_INTCR;
    wire hit_isr = req.addr == `RA_INTSR;

    assign bus_ack = ack_q;
    assign bus_rdata = rdata_q;

    // ======================================================
    // Configuration registers
    logic [9:0] addr_q;
    logic [7:0] icr_reg_q;
    logic [9:0] icr_fifo_q;

    wire addr_wr = wr & hit_addr;
    wire icr_wr = wr & hit_icr;
    wire [9:0] addr_d = fifo_mode ? req.wdata :
        {req.wdata[7:0], addr_q[`ADDR_REG_LSB-1:0]};

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            addr_q <= `RST_ADDR;
            icr_reg_q <= `RST_ICR_REG;
            icr_fifo_q <= `RST_ICR_FIFO;
        end else begin
            if (addr_wr) begin
                addr_q <= addr_d;
            end
            if (icr_wr && !fifo_mode) begin
                icr_reg_q <= req.wdata[7:0] & `ICR_REG_MASK;
            end
            if (icr_wr && fifo_mode) begin
                icr_fifo_q <= req.wdata & `ICR_FIFO_MASK;
            end
        end
    end

    assign own_addr = addr_q;

    wire auto_clr = fifo_mode ? icr_fifo_q[`ICR_FIFO_AUTOCLR] :
        icr_reg_q[`ICR_REG_AUTOCLR];
    wire force_on = fifo_mode ? icr_fifo_q[`ICR_FIFO_FORCE] :
        icr_reg_q[`ICR_REG_FORCE];
    wire [6:0] irq_en = fifo_mode ? icr_fifo_q[6:0] :
        {3'b000, icr_reg_q[3:0]};

    // ======================================================
    // Receive capture
    logic [7:0] rx_byte_q;
    logic [7:0] gc_byte_q;

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            rx_byte_q <= `RST_BYTE;
            gc_byte_q <= `RST_BYTE;
        end else begin
            if (rx_beat.valid && !fifo_mode) begin
                rx_byte_q <= rx_beat.data;
            end
            if (gc_valid) begin
                gc_byte_q <= gc_byte;
            end
        end
    end

    // ======================================================
    // Receive queue
    logic [8:0] rxq_head;
    logic rxq_full;

    wire rxq_flush = fifo_rst | (wr & hit_rx & fifo_mode);
    wire rxq_push = rx_beat.valid & fifo_mode;
    wire rxq_pop = rd & hit_rx & fifo_mode;
    // Overflow is raised here since only this block sees the full queue
    wire rxq_ovf = rxq_push & rxq_full;

    rx_queue u_rx_queue (
        .clk(sys_clk),
        .rst_b(rst_sync_b),
        .flush(rxq_flush),
        .push(rxq_push),
        .push_data({rx_beat.first, rx_beat.data}),
        .pop(rxq_pop),
        .head(rxq_head),
        .empty(rxq_empty),
        .full(rxq_full)
    );

    // ======================================================
    // Interrupt flags
    logic [6:0] flags;

    wire [6:0] ovf_vec = {6'h00, rxq_ovf} << `FIFO_OVF_BIT;
    wire [6:0] evt = fifo_mode ? (fifo_events | ovf_vec) :
        {3'b000, reg_events};
    wire [6:0] wclr = (wr & hit_isr) ? req.wdata[6:0] : 7'h00;
    wire rd_clr = rd & hit_isr & auto_clr;

    irq_unit u_irq_unit (
        .clk(sys_clk),
        .rst_b(rst_sync_b),
        .set(evt),
        .wclr(wclr),
        .rd_clr(rd_clr),
        .enable(irq_en),
        .force_on(force_on),
        .flags(flags),
        .irq(irq)
    );

    // ======================================================
    // Read selection, fields by active mode
    wire [9:0] rd_rx = fifo_mode ? {1'b0, rxq_head & {9{~rxq_empty}}} :
        {2'b00, rx_byte_q};
    wire [9:0] rd_addr = fifo_mode ? addr_q :
        {2'b00, addr_q[9:`ADDR_REG_LSB]};
    wire [9:0] rd_icr = fifo_mode ? icr_fifo_q : {2'b00, icr_reg_q};
    wire [9:0] rd_isr = fifo_mode ? {3'b000, flags} :
        {6'h00, flags[3:0]};
    wire [9:0] rd_mux =
        hit_rx ? rd_rx :
        hit_gc ? {2'b00, gc_byte_q} :
        hit_addr ? rd_addr :
        hit_icr ? rd_icr :
        hit_isr ? rd_isr : `RST_WORD;

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ack_q <= 1'b0;
            rdata_q <= `RST_WORD;
        end else begin
            ack_q <= taken;
            if (rd) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // ======================================================
    // Transmit queue abort
    i2c_rx_pkg::abort_state_t ab_q;
    i2c_rx_pkg::abort_state_t ab_d;
    logic flush_q;

    // The write-only location still reacts to a read in queue mode
    wire tx_flush = fifo_rst | (rd & hit_txq & fifo_mode);

    always_comb begin
        ab_d = ab_q;
        unique case (ab_q)
            i2c_rx_pkg::ab_idle: begin
                if (tx_flush && link_tx_busy) begin
                    ab_d = i2c_rx_pkg::ab_wait_byte;
                end else if (tx_flush && link_rx_busy) begin
                    ab_d = i2c_rx_pkg::ab_nack_stop;
                end
            end
            i2c_rx_pkg::ab_wait_byte: begin
                if (link_byte_done) begin
                    ab_d = i2c_rx_pkg::ab_stop;
                end
            end
            i2c_rx_pkg::ab_stop: begin
                ab_d = i2c_rx_pkg::ab_idle;
            end
            i2c_rx_pkg::ab_nack_stop: begin
                ab_d = i2c_rx_pkg::ab_idle;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ab_q <= i2c_rx_pkg::ab_idle;
            flush_q <= 1'b0;
        end else begin
            ab_q <= ab_d;
            flush_q <= tx_flush;
        end
    end

    assign tx_queue_flush = flush_q;
    assign abort_stop = ab_q == i2c_rx_pkg::ab_stop;
    assign abort_nack_stop = ab_q == i2c_rx_pkg::ab_nack_stop;

    // ======================================================
    // Checks
    sequence s_tx_abort_start;
        tx_flush && link_tx_busy && ab_q == i2c_rx_pkg::ab_idle;
    endsequence

    sequence s_rx_abort_start;
        tx_flush && !link_tx_busy && link_rx_busy &&
            ab_q == i2c_rx_pkg::ab_idle;
    endsequence

    sequence s_byte_end;
        ab_q == i2c_rx_pkg::ab_wait_byte && link_byte_done;
    endsequence

    property p_tx_abort;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        s_byte_end |=> abort_stop ##1 !abort_stop;
    endproperty
    a_tx_abort: assert property (p_tx_abort)
        else $error("stop not issued after byte in progress");

    property p_tx_hold;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        s_tx_abort_start ##1 !link_byte_done |=> !abort_stop;
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("stop issued before byte finished");

    property p_rx_abort;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        s_rx_abort_start |=> abort_nack_stop && !abort_stop
            ##1 !abort_nack_stop;
    endproperty
    a_rx_abort: assert property (p_rx_abort)
        else $error("nack and stop not issued on receive abort");

    property p_tx_read_flush;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        rd && hit_txq && fifo_mode |=> tx_queue_flush;
    endproperty
    a_tx_read_flush: assert property (p_tx_read_flush)
        else $error("read of transmit location did not flush");

    property p_rx_write_flush;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        wr && hit_rx && fifo_mode |=> rxq_empty;
    endproperty
    a_rx_write_flush: assert property (p_rx_write_flush)
        else $error("write to receive location did not empty queue");

    property p_rx_byte;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        rx_beat.valid && !fifo_mode |=> rx_byte_q == $past(rx_beat.data);
    endproperty
    a_rx_byte: assert property (p_rx_byte)
        else $error("received byte not held");

    property p_gc_byte;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        gc_valid |=> gc_byte_q == $past(gc_byte);
    endproperty
    a_gc_byte: assert property (p_gc_byte)
        else $error("general call byte not captured");

    property p_addr_fifo;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        addr_wr && fifo_mode |=> own_addr == $past(bus_wdata);
    endproperty
    a_addr_fifo: assert property (p_addr_fifo)
        else $error("queue mode address not stored");

    property p_ack;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        taken |=> bus_ack ##1 !bus_ack;
    endproperty
    a_ack: assert property (p_ack)
        else $error("strobe not acknowledged once");

endmodule : i2c_rx_addr_irq_control

// ===== rtl/i2c_rx_pkg.sv
/*
 * Types shared by the receive, address and interrupt-control block.
 * Assumes nothing of its surroundings.
 */
package i2c_rx_pkg;

    // ======================================================
    // Carriers
    typedef struct packed {
        logic valid;
        logic first;
        logic [7:0] data;
    } rx_beat_t;

    typedef struct packed {
        logic cs;
        logic stb;
        logic we;
        logic [3:0] addr;
        logic [9:0] wdata;
    } bus_req_t;

    // ======================================================
    // Abort sequencer states, one bit changing per step except stop back to idle
    typedef enum logic [1:0] {
        ab_idle = 2'b00,
        ab_wait_byte = 2'b01,
        ab_stop = 2'b11,
        ab_nack_stop = 2'b10
    } abort_state_t;

endpackage : i2c_rx_pkg

// ===== rtl/irq_unit.sv
/*
 * Sticky interrupt flags with write-one clear, read clear, enables and
 * a force bit driving one registered request.
 * Assumes event pulses and clears on the same clock.
 */
`timescale 1ns/1ps

module irq_unit (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [6:0] set,
    input wire logic [6:0] wclr,
    input wire logic rd_clr,
    input wire logic [6:0] enable,
    input wire logic force_on,
    output logic [6:0] flags,
    output logic irq
);

    wire [6:0] clr_only = (wclr | {7{rd_clr}}) & ~set;
    wire irq_d = (|(flags & enable)) | force_on;

    // ======================================================
    // One flag per bit; an event beats a clear in the same cycle
    genvar i;
    generate
        for (i = 0; i < 7; i++) begin : g_flag
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    flags[i] <= 1'b0;
                end else begin
                    flags[i] <= (flags[i] & ~(wclr[i] | rd_clr)) | set[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_d;
        end
    end

    property p_force;
        @(posedge clk) disable iff (!rst_b)
        force_on |=> irq;
    endproperty
    a_force: assert property (p_force)
        else $error("force bit did not raise the request");

    property p_enabled;
        @(posedge clk) disable iff (!rst_b)
        (|(flags & enable)) |=> irq;
    endproperty
    a_enabled: assert property (p_enabled)
        else $error("enabled flag did not raise the request");

    property p_quiet;
        @(posedge clk) disable iff (!rst_b)
        (!force_on && (flags & enable) == 7'h00) |=> !irq;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("request raised with no cause");

    property p_clear;
        @(posedge clk) disable iff (!rst_b)
        clr_only != 7'h00 |=> (flags & $past(clr_only)) == 7'h00;
    endproperty
    a_clear: assert property (p_clear)
        else $error("cleared flag still set");

endmodule : irq_unit

// ===== rtl/rx_queue.sv
/*
 * Receive queue of 32 entries of first-byte flag plus data byte.
 * Assumes a reset released synchronously to clk.
 */
`timescale 1ns/1ps
`include "i2c_block_regs.svh"

module rx_queue (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic flush,
    input wire logic push,
    input wire logic [8:0] push_data,
    input wire logic pop,
    output logic [8:0] head,
    output logic empty,
    output logic full
);

    logic [8:0] mem_q [`RXQ_DEPTH];
    logic [`RXQ_AW:0] wr_q;
    logic [`RXQ_AW:0] rd_q;
    wire do_push = push & ~full & ~flush;
    wire do_pop = pop & ~empty & ~flush;

    assign empty = wr_q == rd_q;
    assign full = (wr_q[`RXQ_AW] != rd_q[`RXQ_AW]) &&
        (wr_q[`RXQ_AW-1:0] == rd_q[`RXQ_AW-1:0]);
    assign head = mem_q[rd_q[`RXQ_AW-1:0]];

    // ======================================================
    // Pointers; flush wins so no stale entry survives
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q <= '0;
            rd_q <= '0;
        end else if (flush) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + (`RXQ_AW+1)'(do_push);
            rd_q <= rd_q + (`RXQ_AW+1)'(do_pop);
        end
    end

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_q[wr_q[`RXQ_AW-1:0]] <= push_data;
        end
    end

    property p_flush_empties;
        @(posedge clk) disable iff (!rst_b)
        flush |=> empty;
    endproperty
    a_flush_empties: assert property (p_flush_empties)
        else $error("flush left entries in the queue");

endmodule : rx_queue

// ===== verification/i2c_engine_model.sv
/*
 * Behavioural bit-level engine beside the receive block: bytes, general
 * call, events, busy levels and byte-done pulses.
 * Assumes the bench calls its tasks between clock edges.
 */
`timescale 1ns/1ps

module i2c_engine_model (
    input wire logic sys_clk,
    output i2c_rx_pkg::rx_beat_t rx_beat,
    output logic gc_valid,
    output logic [7:0] gc_byte,
    output logic link_tx_busy,
    output logic link_rx_busy,
    output logic link_byte_done,
    output logic [3:0] reg_events,
    output logic [6:0] fifo_events
);
    // ==========================================================
    // Idle levels
    initial begin
        rx_beat = 10'h000;
        gc_valid = 1'b0;
        gc_byte = 8'h00;
        link_tx_busy = 1'b0;
        link_rx_busy = 1'b0;
        link_byte_done = 1'b0;
        reg_events = 4'h0;
        fifo_events = 7'h00;
    end

    // ==========================================================
    // One-cycle strobes; kind 0 byte, 1 general call, 2/3 events, else byte done
    task automatic fire(input int kind, input int idx, input logic [7:0] data);
        @(posedge sys_clk);
        #1;
        case (kind)
            0: rx_beat = {1'b1, idx[0], data};
            1: gc_valid = 1'b1;
            2: reg_events[idx] = 1'b1;
            3: fifo_events[idx] = 1'b1;
            default: link_byte_done = 1'b1;
        endcase
        gc_byte = data;
        @(posedge sys_clk);
        #1;
        // Stale data would hide a late capture, so show its inverse
        rx_beat = {2'b00, ~data};
        gc_byte = ~data;
        gc_valid = 1'b0;
        reg_events = 4'h0;
        fifo_events = 7'h00;
        link_byte_done = 1'b0;
    endtask : fire

    task automatic set_busy(input logic tx, input logic rx);
        @(posedge sys_clk);
        #1;
        link_tx_busy = tx;
        link_rx_busy = rx;
    endtask : set_busy

endmodule : i2c_engine_model

// ===== verification/test_i2c_rx_addr_irq_control.sv
/*
 * Self-checking bench: register accesses, receive paths, interrupts, abort.
 * Assumes the engine model drives the link-side inputs.
 */
`timescale 1ns/1ps
`include "i2c_block_regs.svh"

module test_i2c_rx_addr_irq_control;
    logic sys_clk, rst_b, fifo_mode, fifo_rst, bus_cs, bus_stb, bus_we, bus_ack;
    logic [3:0] bus_addr, reg_events;
    logic [9:0] bus_wdata, bus_rdata, own_addr, flush_seen, stop_seen, nack_seen;
    i2c_rx_pkg::rx_beat_t rx_beat;
    logic gc_valid, link_tx_busy, link_rx_busy, link_byte_done;
    logic tx_queue_flush, abort_stop, abort_nack_stop, rxq_empty, irq;
    logic [7:0] gc_byte;
    logic [6:0] fifo_events;
    int fails, total_checks, i;

    i2c_rx_addr_irq_control DUT (.sys_clk(sys_clk), .rst_b(rst_b), .fifo_mode(fifo_mode), .fifo_rst(fifo_rst),
        .bus_cs(bus_cs), .bus_stb(bus_stb), .bus_we(bus_we), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .bus_ack(bus_ack), .rx_beat(rx_beat), .gc_valid(gc_valid), .gc_byte(gc_byte),
        .link_tx_busy(link_tx_busy), .link_rx_busy(link_rx_busy), .link_byte_done(link_byte_done),
        .reg_events(reg_events), .fifo_events(fifo_events), .own_addr(own_addr), .tx_queue_flush(tx_queue_flush),
        .abort_stop(abort_stop), .abort_nack_stop(abort_nack_stop), .rxq_empty(rxq_empty), .irq(irq));

    i2c_engine_model eng (.sys_clk(sys_clk), .rx_beat(rx_beat), .gc_valid(gc_valid), .gc_byte(gc_byte),
        .link_tx_busy(link_tx_busy), .link_rx_busy(link_rx_busy), .link_byte_done(link_byte_done),
        .reg_events(reg_events), .fifo_events(fifo_events));

    // ==========================================================
    // Clock, pulse counters, watchdog
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    initial begin
        flush_seen = 10'h000;
        stop_seen = 10'h000;
        nack_seen = 10'h000;
    end

    always @(posedge sys_clk) begin
        if (tx_queue_flush === 1'b1) flush_seen = flush_seen + 10'h001;
        if (abort_stop === 1'b1) stop_seen = stop_seen + 10'h001;
        if (abort_nack_stop === 1'b1) nack_seen = nack_seen + 10'h001;
    end

    initial begin
        #100000;
        fails++;
        tally_and_finish();
    end

    // ==========================================================
    // Bus and compare tasks
    task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic access(input logic we, input logic [3:0] a, input logic [9:0] d, output logic [9:0] r);
        int n;
        @(posedge sys_clk);
        #1;
        bus_cs = 1'b1;
        bus_stb = 1'b1;
        bus_we = we;
        bus_addr = a;
        bus_wdata = d;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (bus_ack !== 1'b1 && n < 8);
        r = bus_rdata;
        check("bus_ack", 10'h001, {9'h000, bus_ack});
        #1;
        bus_cs = 1'b0;
        bus_stb = 1'b0;
    endtask : access

    task automatic wr(input logic [3:0] a, input logic [9:0] d);
        logic [9:0] r;
        access(1'b1, a, d, r);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [9:0] e, input string what);
        logic [9:0] r;
        access(1'b0, a, 10'h000, r);
        check(what, e, r);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : idle

    task automatic mode(input logic m);
        idle(1);
        fifo_mode = m;
    endtask : mode

    task automatic tally_and_finish;
        if (fails == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    // ==========================================================
    // Scenarios
    initial begin
        {rst_b, fifo_mode, fifo_rst, bus_cs, bus_stb, bus_we} = 6'h00;
        bus_addr = 4'h0;
        bus_wdata = 10'h000;
        idle(3);
        rst_b = 1'b1;
        idle(3);
        for (i = 0; i < 2; i++) begin
            mode(i[0]);
            rd(`RA_ADDR, `RST_ADDR, "address reset");
            rd(`RA_INTCR, 10'h000, "control reset");
        end
        wr(`RA_ADDR, 10'h2a5);
        rd(`RA_ADDR, 10'h2a5, "queue address");
        wr(`RA_INTCR, 10'h3ff);
        rd(`RA_INTCR, `ICR_FIFO_MASK, "queue control");
        idle(2);
        check("forced irq", 10'h001, {9'h000, irq});
        wr(`RA_INTCR, 10'h000);
        mode(1'b0);
        rd(`RA_ADDR, 10'h0a9, "register address");
        wr(`RA_ADDR, 10'h05a);
        check("own_addr", 10'h169, own_addr);
        wr(`RA_INTCR, 10'h3ff);
        rd(`RA_INTCR, {2'b00, `ICR_REG_MASK}, "register control");
        wr(`RA_INTCR, 10'h000);
        idle(2);
        check("unforced irq", 10'h000, {9'h000, irq});
        eng.fire(0, 0, 8'ha5);
        rd(`RA_RX, 10'h0a5, "receive byte");
        eng.fire(1, 0, 8'h3c);
        rd(`RA_GC, 10'h03c, "general call byte");
        for (i = 0; i < 4; i++) begin
            wr(`RA_INTCR, 10'h001 << i);
            eng.fire(2, i, 8'h00);
            idle(2);
            check("register irq", 10'h001, {9'h000, irq});
            wr(`RA_INTSR, 10'h001 << i);
            idle(2);
            check("register irq clear", 10'h000, {9'h000, irq});
        end
        mode(1'b1);
        wr(`RA_RX, 10'h000);
        wr(`RA_INTSR, 10'h3ff);
        eng.fire(0, 1, 8'h81);
        eng.fire(0, 0, 8'h7e);
        rd(`RA_RX, 10'h181, "first entry");
        rd(`RA_RX, 10'h07e, "second entry");
        eng.fire(0, 1, 8'h55);
        wr(`RA_RX, 10'h3ff);
        check("rxq_empty", 10'h001, {9'h000, rxq_empty});
        rd(`RA_RX, 10'h000, "flushed queue");
        for (i = 0; i < 7; i++) begin
            wr(`RA_INTCR, 10'h001 << i);
            eng.fire(3, i, 8'h00);
            rd(`RA_INTSR, 10'h001 << i, "status flag");
            check("queue irq", 10'h001, {9'h000, irq});
            wr(`RA_INTSR, 10'h001 << i);
            rd(`RA_INTSR, 10'h000, "status cleared");
            check("queue irq clear", 10'h000, {9'h000, irq});
        end
        wr(`RA_INTCR, 10'h200);
        eng.fire(3, 2, 8'h00);
        idle(2);
        check("disabled irq", 10'h000, {9'h000, irq});
        rd(`RA_INTSR, 10'h004, "status before read");
        rd(`RA_INTSR, 10'h000, "status after read");
        // The 33rd byte meets a full queue, is dropped and raises overflow
        for (i = 0; i < 33; i++) begin
            eng.fire(0, 1, i[7:0]);
        end
        rd(`RA_INTSR, 10'h001, "overflow flag");
        rd(`RA_RX, 10'h100, "full queue head");
        eng.set_busy(1'b1, 1'b0);
        rd(`RA_TXQ, 10'h000, "transmit location");
        idle(4);
        check("flush count", 10'h001, flush_seen);
        check("early stop", 10'h000, stop_seen);
        eng.fire(4, 0, 8'h00);
        idle(2);
        check("stop after byte", 10'h001, stop_seen);
        eng.set_busy(1'b0, 1'b1);
        fifo_rst = 1'b1;
        idle(1);
        fifo_rst = 1'b0;
        idle(3);
        check("flush count", 10'h002, flush_seen);
        check("nack stop", 10'h001, nack_seen);
        check("stop count", 10'h001, stop_seen);
        tally_and_finish();
    end

endmodule : test_i2c_rx_addr_irq_control
